// >>> rtl/sef_fifo.sv
`timescale 1ns/1ps
module sef_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_ptr_q;
	logic [AW:0] rd_ptr_q;

	wire full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
	wire empty = wr_ptr_q == rd_ptr_q;
	wire do_push = in_valid && !full;
	wire do_pop = out_ready && !empty;

	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem_q[rd_ptr_q[AW-1:0]];

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem_q[wr_ptr_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || flush) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_q + (AW+1)'(do_push);
			rd_ptr_q <= rd_ptr_q + (AW+1)'(do_pop);
		end
	end
endmodule // sef_fifo

// >>> rtl/sef_front_end.sv
`timescale 1ns/1ps
// Function
// - reset leaves device deselected, standby set, latch and busy flags zero, protect bits untouched.
// - a select already low after reset is ignored until chip select has been high.
// - select low means active; deselected device enters standby only when not busy.
// - pause is only entered while selected; master keeps select low first.
// - paused device floats output, ignores data and clock, keeps bit position.
// - pause starts when hold falls with serial clock low.
// - deselect while paused aborts an unfinished command but keeps latch and busy flags.
// - a complete write shifted in before a paused deselect still starts its cycle.
// - writes run only when the clock count is a whole number of bytes.
// - data-modifying commands need the write enable latch set.
// - protect bits select none, upper quarter, upper half or whole array.
// - write protect pin guards the protect bits against status writes.
// - a command runs only if select rises between last bit and next edge.
// - last bit is opcode bit eight or data byte bit eight; reads exempt.
// - commands are whole bytes, msb first, first byte is the opcode.
// - an unknown opcode parks the decoder until deselect.
// - opcodes for set latch, clear latch, status read and status write.
// - opcode 03h reads the array after two address bytes.
// - opcode 02h writes the array after two address bytes.
// - opcode 83h reads id page or lock state, chosen by address; front end issues it as a plain rd_req at that address, no id flag.
// - opcode 82h writes or locks the id page, chosen by address.
// - busy flag is one during a self-timed write, zero otherwise.
// - lock bit set with protect pin low refuses status writes.
// - write enable latch clears on reset, clear command and write completion.
module sef_front_end (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic spi_clk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	input wire logic spi_hold_n,
	input wire logic spi_wp_n,
	output logic spi_miso_o,
	output logic spi_miso_oe,
	output logic device_selected,
	output logic standby,
	output logic paused,
	output logic write_enable_latch,
	output logic write_in_progress,
	input wire logic status_write_lock,
	input wire logic block_protect_high,
	input wire logic block_protect_low,
	output logic status_wr_start,
	output logic [7:0] status_wr_data,
	output logic mem_wr_start,
	output logic [15:0] mem_wr_addr,
	output logic mem_wr_id_space,
	output logic mem_wr_id_lock,
	output logic wr_data_valid,
	input wire logic wr_data_ready,
	output logic [7:0] wr_data,
	input wire logic cycle_done,
	output logic rd_req,
	output logic [15:0] rd_addr,
	input wire logic [7:0] rd_data
);
	typedef enum logic [2:0] {ST_IDLE, ST_OPCODE, ST_ADDR, ST_DATA, ST_READ, ST_WAIT} sef_state_type;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	// pin order: hold, wp, mosi, cs, clk
	wire [4:0] pin_raw = {spi_hold_n, spi_wp_n, spi_mosi, spi_cs_n, spi_clk};
	logic [4:0] meta_q;
	logic [4:0] sync_q;
	logic sck_prev_q;
	logic cs_prev_q;
	logic armed_q;
	logic paused_q;
	sef_state_type state_q;
	sef_state_type state_d;
	logic [7:0] rx_q;
	logic [2:0] bit_cnt_q;
	logic [2:0] byte_cnt_q;
	logic [7:0] opcode_q;
	logic [15:0] addr_q;
	logic rd_req_q;
	logic rd_ack_q;
	logic [7:0] rd_byte_q;
	logic [7:0] tx_q;
	logic miso_q;
	logic wel_q;
	logic wip_q;
	logic overflow_q;
	logic [7:0] stat_wr_q;
	logic sw_start_q;
	logic mw_start_q;
	logic [15:0] wr_addr_q;
	logic wr_id_q;
	logic wr_lock_q;
	logic [7:0] status_byte;
	logic fifo_in_ready;
	logic fifo_out_valid;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= pin_raw;
			sync_q <= meta_q;
		end
	end

	wire sck_s = sync_q[0];
	wire cs_n_s = sync_q[1];
	wire mosi_s = sync_q[2];
	wire wp_n_s = sync_q[3];
	wire hold_n_s = sync_q[4];

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sck_prev_q <= 1'b0;
			cs_prev_q <= 1'b0;
		end else begin
			sck_prev_q <= sck_s;
			cs_prev_q <= cs_n_s;
		end
	end

	wire sck_rise = sck_s && !sck_prev_q;
	wire sck_fall = !sck_s && sck_prev_q;
	wire cs_rise = armed_q && cs_n_s && !cs_prev_q;
	wire selected = armed_q && !cs_n_s;

	// the synchronised select resets low, so a select held low at reset is never taken
	always_ff @(posedge core_clk) begin
		if (rst) begin
			armed_q <= 1'b0;
		end else if (cs_n_s) begin
			armed_q <= 1'b1;
		end
	end

	a_arm_first: assert property (!armed_q |-> !device_selected)
		else $error("device selected before chip select was seen high");

	wire pause_enter = selected && !paused_q && !hold_n_s && !sck_s;
	wire pause_leave = paused_q && hold_n_s && !sck_s;

	always_ff @(posedge core_clk) begin
		if (rst || !selected) begin
			paused_q <= 1'b0;
		end else if (pause_enter) begin
			paused_q <= 1'b1;
		end else if (pause_leave) begin
			paused_q <= 1'b0;
		end
	end

	// the pause flag drops one cycle after deselect, so look at the select it was built from
	a_pause_select: assert property (paused_q |-> $past(device_selected))
		else $error("pause held while deselected");
	a_pause_entry: assert property ($rose(paused_q) |-> $past(!sck_s) && $past(!hold_n_s))
		else $error("pause began with serial clock high");

	// paused: clock edges are dropped, so the bit position survives the pause
	wire step_rise = selected && !paused_q && sck_rise;
	wire step_fall = selected && !paused_q && sck_fall;
	wire [7:0] rx_byte = {rx_q[6:0], mosi_s};
	wire byte_done = step_rise && (bit_cnt_q == sef_pkg::LAST_BIT);

	always_ff @(posedge core_clk) begin
		if (step_rise) begin
			rx_q <= rx_byte;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst || !selected) begin
			bit_cnt_q <= '0;
			byte_cnt_q <= '0;
		end else if (step_rise) begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
			if (byte_done && byte_cnt_q != sef_pkg::LAST_BIT) begin
				byte_cnt_q <= byte_cnt_q + 3'h1;
			end
		end
	end

	a_pause_stall: assert property (paused_q && $past(paused_q) |-> $stable(bit_cnt_q) && $stable(rx_q))
		else $error("bit position moved while paused");

	wire rx_read = (rx_byte == sef_pkg::OP_MEM_READ) || (rx_byte == sef_pkg::OP_ID_READ);
	wire rx_write = (rx_byte == sef_pkg::OP_MEM_WRITE) || (rx_byte == sef_pkg::OP_ID_WRITE);
	wire rx_known = rx_read || rx_write || rx_byte inside {sef_pkg::OP_SET_WEL, sef_pkg::OP_CLR_WEL,
		sef_pkg::OP_STATUS_READ, sef_pkg::OP_STATUS_WRITE};
	// only status reads are served while a cycle runs; anything else is parked as no-op
	wire rx_blocked = wip_q && (rx_byte != sef_pkg::OP_STATUS_READ);
	wire is_read_q = (opcode_q == sef_pkg::OP_MEM_READ) || (opcode_q == sef_pkg::OP_ID_READ);
	wire is_write_q = (opcode_q == sef_pkg::OP_MEM_WRITE) || (opcode_q == sef_pkg::OP_ID_WRITE);
	wire is_stat_rd_q = opcode_q == sef_pkg::OP_STATUS_READ;

	always_comb begin
		state_d = state_q;
		if (!selected) begin
			state_d = ST_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE: state_d = ST_OPCODE;
				ST_OPCODE: begin
					if (byte_done) begin
						if (rx_blocked || !rx_known) begin
							state_d = ST_WAIT;
						end else if (rx_byte == sef_pkg::OP_STATUS_READ) begin
							state_d = ST_READ;
						end else if (rx_byte == sef_pkg::OP_STATUS_WRITE) begin
							state_d = ST_DATA;
						end else if (rx_read || rx_write) begin
							state_d = ST_ADDR;
						end else begin
							state_d = ST_WAIT;
						end
					end
				end
				ST_ADDR: begin
					if (byte_done && byte_cnt_q == sef_pkg::LAST_ADDR_COUNT) begin
						state_d = is_read_q ? ST_READ : ST_DATA;
					end
				end
				ST_DATA, ST_READ, ST_WAIT: state_d = state_q;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	sequence s_bad_opcode;
		byte_done && state_q == ST_OPCODE && !rx_known;
	endsequence
	a_bad_opcode: assert property (s_bad_opcode |=> state_q == ST_WAIT)
		else $error("unknown opcode did not park the decoder");
	a_deselect_abort: assert property (cs_rise |=> state_q == ST_IDLE && bit_cnt_q == 3'h0)
		else $error("deselect did not reset the protocol");

	always_ff @(posedge core_clk) begin
		if (rst) begin
			opcode_q <= sef_pkg::OP_NONE;
		end else if (byte_done && state_q == ST_OPCODE) begin
			opcode_q <= rx_blocked ? sef_pkg::OP_NONE : rx_byte;
		end
	end

	wire addr_last = byte_done && state_q == ST_ADDR && byte_cnt_q == sef_pkg::LAST_ADDR_COUNT;
	wire read_next = byte_done && state_q == ST_READ && !is_stat_rd_q;

	always_ff @(posedge core_clk) begin
		if (byte_done && state_q == ST_ADDR) begin
			addr_q <= {addr_q[7:0], rx_byte};
		end else if (read_next) begin
			addr_q <= addr_q + 16'h0001;
		end
	end

	// array answers one cycle after the request, well before the next falling edge
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rd_req_q <= 1'b0;
			rd_ack_q <= 1'b0;
			rd_byte_q <= '0;
		end else begin
			rd_req_q <= (addr_last && is_read_q) || read_next;
			rd_ack_q <= rd_req_q;
			if (rd_ack_q) begin
				rd_byte_q <= rd_data;
			end
		end
	end

	always_comb begin
		status_byte = '0;
		status_byte[sef_pkg::STAT_WIP_BIT] = wip_q;
		status_byte[sef_pkg::STAT_WEL_BIT] = wel_q;
		status_byte[sef_pkg::STAT_BP_LOW_BIT] = block_protect_low;
		status_byte[sef_pkg::STAT_BP_HIGH_BIT] = block_protect_high;
		status_byte[sef_pkg::STAT_LOCK_BIT] = status_write_lock;
	end

	wire [7:0] tx_load = is_stat_rd_q ? status_byte : rd_byte_q;
	wire tx_shift = step_fall && state_q == ST_READ;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			miso_q <= 1'b0;
			tx_q <= '0;
		end else if (tx_shift && bit_cnt_q == 3'h0) begin
			miso_q <= tx_load[7];
			tx_q <= {tx_load[6:0], 1'b0};
		end else if (tx_shift) begin
			miso_q <= tx_q[7];
			tx_q <= {tx_q[6:0], 1'b0};
		end
	end

	a_tx_on_fall: assert property ($changed(spi_miso_o) |-> $past(step_fall))
		else $error("serial output moved outside a falling clock edge");

	// execution is decided only at the select rising edge, on a byte boundary
	wire aligned = bit_cnt_q == 3'h0;
	wire hw_protect = status_write_lock && !wp_n_s;
	wire prot_hit = block_protect_high ? (block_protect_low || addr_q >= sef_pkg::PROT_HALF_BASE)
		: (block_protect_low && addr_q >= sef_pkg::PROT_QUARTER_BASE);
	wire mem_prot = (opcode_q == sef_pkg::OP_MEM_WRITE) && prot_hit;
	wire exec_set = cs_rise && state_q == ST_WAIT && opcode_q == sef_pkg::OP_SET_WEL
		&& byte_cnt_q == sef_pkg::SET_CLR_BYTES && aligned;
	wire exec_clr = cs_rise && state_q == ST_WAIT && opcode_q == sef_pkg::OP_CLR_WEL
		&& byte_cnt_q == sef_pkg::SET_CLR_BYTES && aligned;
	wire exec_sw = cs_rise && state_q == ST_DATA && opcode_q == sef_pkg::OP_STATUS_WRITE
		&& byte_cnt_q == sef_pkg::STATUS_WRITE_BYTES && aligned && wel_q && !hw_protect;
	// holds during a pause too: a complete write still starts when select rises
	wire exec_mw = cs_rise && state_q == ST_DATA && is_write_q && byte_cnt_q >= sef_pkg::MEM_WRITE_MIN_BYTES
		&& aligned && wel_q && !overflow_q && !mem_prot;
	wire cycle_end = cycle_done && wip_q;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wip_q <= 1'b0;
		end else if (exec_sw || exec_mw) begin
			wip_q <= 1'b1;
		end else if (cycle_end) begin
			wip_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wel_q <= 1'b0;
		end else if (exec_set) begin
			wel_q <= 1'b1;
		end else if (exec_clr || cycle_end) begin
			wel_q <= 1'b0;
		end
	end

	a_reset_flags: assert property (@(posedge core_clk) disable iff (1'b0)
		rst |=> !write_enable_latch && !write_in_progress && !device_selected && !spi_miso_oe)
		else $error("reset left a flag or the select set");
	a_write_gated: assert property ($rose(wip_q) |-> $past(wel_q) && $past(bit_cnt_q) == 3'h0)
		else $error("write cycle started without latch or on a bit offset");
	a_wel_done: assert property (cycle_end |=> !wel_q && !wip_q)
		else $error("cycle end left latch or busy set");
	a_protect_block: assert property (mem_wr_start |-> $past(!mem_prot) && $past(state_q) == ST_DATA)
		else $error("write into a protected block started");
	a_status_lock: assert property (status_wr_start |-> $past(!hw_protect) && $past(wel_q))
		else $error("status write accepted while locked");
	a_standby_busy: assert property (wip_q |-> !standby)
		else $error("standby reported during a write cycle");

	wire data_push = byte_done && state_q == ST_DATA && is_write_q;

	always_ff @(posedge core_clk) begin
		if (rst || !selected) begin
			overflow_q <= 1'b0;
		end else if (data_push && !fifo_in_ready) begin
			overflow_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			stat_wr_q <= '0;
		end else if (byte_done && state_q == ST_DATA && opcode_q == sef_pkg::OP_STATUS_WRITE) begin
			stat_wr_q <= rx_byte;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sw_start_q <= 1'b0;
			mw_start_q <= 1'b0;
			wr_addr_q <= '0;
			wr_id_q <= 1'b0;
			wr_lock_q <= 1'b0;
		end else begin
			sw_start_q <= exec_sw;
			mw_start_q <= exec_mw;
			if (exec_mw) begin
				wr_addr_q <= addr_q;
				wr_id_q <= opcode_q == sef_pkg::OP_ID_WRITE;
				wr_lock_q <= (opcode_q == sef_pkg::OP_ID_WRITE) && addr_q[sef_pkg::ID_LOCK_ADDR_BIT];
			end
		end
	end

	// discarded commands drop their buffered bytes; the array drains only during its cycle
	wire fifo_flush = (cs_rise && state_q == ST_DATA && is_write_q && !exec_mw) || cycle_end;

	sef_fifo #(
		.WIDTH(sef_pkg::FIFO_WIDTH),
		.DEPTH(sef_pkg::FIFO_DEPTH)
	) u_wr_fifo (
		.clk(core_clk),
		.rst(rst),
		.flush(fifo_flush),
		.in_valid(data_push),
		.in_ready(fifo_in_ready),
		.in_data(rx_byte),
		.out_valid(fifo_out_valid),
		.out_ready(wr_data_ready && wip_q),
		.out_data(wr_data)
	);

	assign wr_data_valid = fifo_out_valid && wip_q;
	assign spi_miso_o = miso_q;
	assign spi_miso_oe = selected && !paused_q && state_q == ST_READ;
	assign device_selected = selected;
	assign standby = !selected && !wip_q;
	assign paused = paused_q;
	assign write_enable_latch = wel_q;
	assign write_in_progress = wip_q;
	assign status_wr_start = sw_start_q;
	assign status_wr_data = stat_wr_q;
	assign mem_wr_start = mw_start_q;
	assign mem_wr_addr = wr_addr_q;
	assign mem_wr_id_space = wr_id_q;
	assign mem_wr_id_lock = wr_lock_q;
	assign rd_req = rd_req_q;
	assign rd_addr = addr_q;
endmodule // sef_front_end

// >>> rtl/sef_pkg.sv
package sef_pkg;
	// opcode byte values
	localparam logic [7:0] OP_SET_WEL = 8'h06;
	localparam logic [7:0] OP_CLR_WEL = 8'h04;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_MEM_READ = 8'h03;
	localparam logic [7:0] OP_MEM_WRITE = 8'h02;
	localparam logic [7:0] OP_ID_READ = 8'h83;
	localparam logic [7:0] OP_ID_WRITE = 8'h82;
	localparam logic [7:0] OP_NONE = 8'h00;

	// status byte layout
	localparam int STAT_WIP_BIT = 0;
	localparam int STAT_WEL_BIT = 1;
	localparam int STAT_BP_LOW_BIT = 2;
	localparam int STAT_BP_HIGH_BIT = 3;
	localparam int STAT_LOCK_BIT = 7;

	// address bit that tells lock access from id page data
	localparam int ID_LOCK_ADDR_BIT = 10;

	// byte counts of a command, opcode included, and the index of the last bit of a byte
	localparam logic [2:0] SET_CLR_BYTES = 3'h1;
	localparam logic [2:0] LAST_ADDR_COUNT = 3'h2;
	localparam logic [2:0] STATUS_WRITE_BYTES = 3'h2;
	localparam logic [2:0] MEM_WRITE_MIN_BYTES = 3'h4;
	localparam logic [2:0] LAST_BIT = 3'h7;

	// first protected address for quarter and half settings
	localparam logic [15:0] PROT_QUARTER_BASE = 16'hc000;
	localparam logic [15:0] PROT_HALF_BASE = 16'h8000;

	// write data buffer
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 32;
endpackage

// >>> testbench/sef_spi_master.sv
`timescale 1ns/1ps
module sef_spi_master (
	input wire logic core_clk,
	output logic spi_clk,
	output logic spi_cs_n,
	output logic spi_mosi,
	output logic spi_hold_n,
	output logic spi_wp_n,
	input wire logic spi_miso_o,
	input wire logic spi_miso_oe
);
	// no pull on the data-out line: an undriven line reads as z and fails any compare
	wire miso_line = spi_miso_oe ? spi_miso_o : 1'bz;
	// select starts low at power-up so the first frame exercises edge arming
	initial begin
		spi_clk = 1'b0;
		spi_cs_n = 1'b0;
		spi_mosi = 1'b0;
		spi_hold_n = 1'b1;
		spi_wp_n = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic set_wp(input logic v);
		spi_wp_n = v;
	endtask
	task automatic sel();
		spi_cs_n = 1'b0;
		tick(4);
	endtask
	// clock is low here, so select rises after the last rising edge and before any other
	task automatic desel();
		spi_cs_n = 1'b1;
		spi_mosi = ~spi_mosi;
		tick(10);
	endtask
	// mode 0; read data taken late in the high phase, where it has long settled
	task automatic bits(input logic [7:0] v, input int n, output logic [7:0] r);
		r = 8'h00;
		for (int i = 0; i < n; i++) begin
			spi_mosi = v[7 - i];
			tick(4);
			spi_clk = 1'b1;
			tick(3);
			r = {r[6:0], miso_line};
			tick(1);
			spi_clk = 1'b0;
		end
	endtask
	// hold only moves with the clock low; clock and data then wiggle to prove they are ignored
	task automatic hold_on();
		tick(2);
		spi_hold_n = 1'b0;
		tick(4);
		repeat (2) begin
			spi_clk = 1'b1;
			spi_mosi = ~spi_mosi;
			tick(4);
			spi_clk = 1'b0;
			tick(4);
		end
	endtask
	task automatic hold_off();
		spi_hold_n = 1'b1;
		tick(4);
	endtask
endmodule // sef_spi_master

// >>> testbench/tb_spi_eeprom_command_front_end.sv
`timescale 1ns/1ps
module tb_spi_eeprom_command_front_end;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic spi_clk, spi_cs_n, spi_mosi, spi_hold_n, spi_wp_n, spi_miso_o, spi_miso_oe;
	logic device_selected, standby, paused, write_enable_latch, write_in_progress;
	logic status_write_lock, block_protect_high, block_protect_low;
	logic status_wr_start, mem_wr_start, mem_wr_id_space, mem_wr_id_lock, wr_data_valid, rd_req;
	logic wr_data_ready, cycle_done;
	logic [7:0] rd_data;
	logic [7:0] status_wr_data, wr_data, r;
	logic [15:0] mem_wr_addr, rd_addr, adr;
	logic [15:0] alist[6] = '{16'h0000, 16'h7fff, 16'h8000, 16'hbfff, 16'hc000, 16'hffff};
	logic [23:0] expq[$];
	logic [7:0] datq[$];
	int err_count = 0;
	int n_checks = 0;
	int cnt = 0;
	integer seed = 40969;

	always #50 core_clk = ~core_clk;

	sef_spi_master m (.core_clk, .spi_clk, .spi_cs_n, .spi_mosi, .spi_hold_n, .spi_wp_n, .spi_miso_o, .spi_miso_oe);
	sef_front_end DUT (.core_clk, .rst, .spi_clk, .spi_cs_n, .spi_mosi, .spi_hold_n, .spi_wp_n, .spi_miso_o,
		.spi_miso_oe, .device_selected, .standby, .paused, .write_enable_latch, .write_in_progress,
		.status_write_lock, .block_protect_high, .block_protect_low, .status_wr_start, .status_wr_data,
		.mem_wr_start, .mem_wr_addr, .mem_wr_id_space, .mem_wr_id_lock, .wr_data_valid, .wr_data_ready,
		.wr_data, .cycle_done, .rd_req, .rd_addr, .rd_data);

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("checks=%0d mismatches=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// an unexpected pulse meets an empty queue and is compared against x, so it always fails
	task automatic note(input logic [23:0] got);
		chk(got, (expq.size() > 0) ? expq.pop_front() : 24'hxx_xxxx);
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	// store side: random drain stalls, read data one cycle after the request, fixed quiet time ends a cycle
	always @(posedge core_clk) begin
		wr_data_ready <= ($random(seed) % 2) != 0;
		rd_data <= rd_addr[7:0] ^ 8'h5a;
		cycle_done <= 1'b0;
		cnt <= 0;
		if (write_in_progress === 1'b1 && wr_data_valid !== 1'b1 && cycle_done !== 1'b1) begin
			cnt <= cnt + 1;
			if (cnt == 20)
				cycle_done <= 1'b1;
		end
		if (status_wr_start === 1'b1)
			note({16'h1000, status_wr_data});
		if (mem_wr_start === 1'b1)
			note({4'h2, 2'b00, mem_wr_id_space, mem_wr_id_lock, mem_wr_addr});
		if (rd_req === 1'b1)
			note({8'h30, rd_addr});
		if (wr_data_valid === 1'b1 && wr_data_ready === 1'b1)
			chk({16'h0000, wr_data}, (datq.size() > 0) ? {16'h0000, datq.pop_front()} : 24'hxx_xxxx);
	end

	task automatic frame(input logic [7:0] q[$], input int tail, input bit hold);
		m.sel();
		foreach (q[i]) m.bits(q[i], 8, r);
		if (tail > 0)
			m.bits(8'hff, tail, r);
		if (hold)
			m.hold_on();
		m.desel();
		if (hold)
			m.hold_off();
	endtask
	task automatic wait_idle();
		int i;
		for (i = 0; i < 3000 && write_in_progress !== 1'b0; i++) m.tick(1);
		if (i == 3000) begin
			chk(24'h00_0001, 24'h00_0000);
			results();
		end
	endtask
	task automatic wr(input logic [7:0] op, input logic [15:0] a, input int n, input logic [1:0] fl, input bit ok);
		logic [7:0] q[$];
		logic [7:0] d;
		frame('{8'h06}, 0, 0);
		q = '{op, a[15:8], a[7:0]};
		for (int i = 0; i < n; i++) begin
			d = 8'($random(seed));
			q.push_back(d);
			if (ok)
				datq.push_back(d);
		end
		if (ok)
			expq.push_back({4'h2, 2'b00, fl, a});
		frame(q, 0, 0);
		wait_idle();
	endtask

	initial begin
		status_write_lock = 1'b0;
		block_protect_high = 1'b0;
		block_protect_low = 1'b0;
		repeat (5) @(posedge core_clk);
		#1;
		rst = 1'b0;
		m.tick(1);
		chk({device_selected, standby, paused, write_enable_latch, write_in_progress, spi_miso_oe}, 24'h00_0010);
		m.tick(4);
		m.bits(8'h06, 8, r);
		chk(device_selected, 1'b0);
		m.desel();
		chk(write_enable_latch, 1'b0);
		done("arming");
		frame('{8'h06}, 0, 0);
		chk(write_enable_latch, 1'b1);
		m.sel();
		chk({device_selected, standby}, 2'b10);
		m.bits(8'h04, 8, r);
		m.desel();
		chk({write_enable_latch, standby}, 2'b01);
		frame('{8'h06}, 1, 0);
		chk(write_enable_latch, 1'b0);
		frame('{8'hff, 8'h06}, 0, 0);
		chk(write_enable_latch, 1'b0);
		done("latch");
		frame('{8'h01, 8'h0c}, 0, 0);
		frame('{8'h06}, 0, 0);
		frame('{8'h01}, 7, 0);
		status_write_lock = 1'b1;
		m.set_wp(1'b0);
		frame('{8'h06}, 0, 0);
		frame('{8'h01, 8'h0c}, 0, 0);
		m.set_wp(1'b1);
		frame('{8'h06}, 0, 0);
		expq.push_back(24'h10_008c);
		frame('{8'h01, 8'h8c}, 0, 0);
		chk(write_in_progress, 1'b1);
		wait_idle();
		chk({write_enable_latch, write_in_progress}, 2'b00);
		status_write_lock = 1'b0;
		done("status write");
		for (int b = 0; b < 4; b++) begin
			for (int k = 0; k < 6; k++) begin
				{block_protect_high, block_protect_low} = 2'(b);
				adr = alist[k];
				wr(8'h02, adr, 1, 2'b00, !(b == 3 || (b == 2 && adr >= 16'h8000) || (b == 1 && adr >= 16'hc000)));
			end
		end
		wr(8'h82, 16'h0010, 1, 2'b10, 1'b1);
		wr(8'h82, 16'h0400, 1, 2'b11, 1'b1);
		{block_protect_high, block_protect_low} = 2'b00;
		wr(8'h02, 16'h1234, 32, 2'b00, 1'b1);
		wr(8'h02, 16'h1234, 33, 2'b00, 1'b0);
		done("array write");
		expq.push_back(24'h30_1240);
		m.sel();
		m.bits(8'h03, 8, r);
		m.bits(8'h12, 8, r);
		m.bits(8'h40, 8, r);
		m.bits(8'h00, 7, r);
		chk(r[6:0], 7'h0d);
		m.desel();
		m.sel();
		m.bits(8'h05, 8, r);
		m.bits(8'h00, 8, r);
		chk(r, 8'h02);
		m.desel();
		expq.push_back(24'h30_0400);
		frame('{8'h83, 8'h04, 8'h00}, 0, 0);
		frame('{8'h04}, 0, 0);
		chk(write_enable_latch, 1'b0);
		done("read");
		m.hold_on();
		chk(paused, 1'b0);
		m.hold_off();
		m.sel();
		m.bits(8'h06, 4, r);
		m.hold_on();
		chk({paused, spi_miso_oe}, 2'b10);
		m.hold_off();
		m.bits(8'h60, 4, r);
		m.desel();
		chk(write_enable_latch, 1'b1);
		m.sel();
		m.bits(8'h04, 6, r);
		m.hold_on();
		m.desel();
		m.hold_off();
		chk(write_enable_latch, 1'b1);
		expq.push_back(24'h20_0020);
		datq.push_back(8'h3c);
		frame('{8'h02, 8'h00, 8'h20, 8'h3c}, 0, 1);
		wait_idle();
		chk(write_enable_latch, 1'b0);
		done("pause");
		chk(24'(expq.size() + datq.size()), 24'h00_0000);
		results();
	end
endmodule // tb_spi_eeprom_command_front_end
